/* File: cpfsi_pkg.sv */
package cpfsi_pkg;

   // ---------------------------------------------------------------
   // bus and register map
   // ---------------------------------------------------------------
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 8;

   localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h03;
   localparam logic [ADDR_W-1:0] OFS_RSVD_A    = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_RSVD_B    = 8'h05;
   localparam logic [ADDR_W-1:0] OFS_IRQ_EN    = 8'h06;
   localparam logic [ADDR_W-1:0] OFS_IRQ_FLAGS = 8'h07;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int unsigned BIT_CANH_HIGH = 7;
   localparam int unsigned BIT_CANH_LOW  = 6;
   localparam int unsigned BIT_CANL_HIGH = 5;
   localparam int unsigned BIT_CANL_LOW  = 4;
   localparam int unsigned BIT_TIMEOUT   = 3;
   localparam int unsigned BIT_CANH_OC   = 1;
   localparam int unsigned BIT_CANL_OC   = 0;

   localparam int unsigned BIT_VF_EN = 4;
   localparam int unsigned BIT_DT_EN = 3;
   localparam int unsigned BIT_OC_EN = 0;

   localparam logic [DATA_W-1:0] STATUS_MASK    = 8'hf8;
   localparam logic [DATA_W-1:0] IRQ_EN_MASK    = 8'h19;
   localparam logic [DATA_W-1:0] IRQ_FLAGS_MASK = 8'hfb;
   localparam logic [DATA_W-1:0] VF_FLAGS_MASK  = 8'hf0;
   localparam logic [DATA_W-1:0] OC_FLAGS_MASK  = 8'h03;
   localparam logic [DATA_W-1:0] READ_NONE      = 8'h00;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [DATA_W-1:0] STATUS_RST    = 8'h00;
   localparam logic [DATA_W-1:0] IRQ_EN_RST    = 8'h00;
   localparam logic [DATA_W-1:0] IRQ_FLAGS_RST = 8'h00;
   localparam logic [DATA_W-1:0] RSVD_RST      = 8'h00;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned REC_TIME_NS   = 1000;
   // plain default, the real figure belongs to the analogue spec
   localparam int unsigned TX_DOM_TIMEOUT_TIME_NS = 500000;
   localparam int unsigned REC_CYC =
      (REC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TX_DOM_TIMEOUT_CYC_DEF =
      TX_DOM_TIMEOUT_TIME_NS / CLK_PERIOD_NS;

   localparam int unsigned CNT_W = 24;
   localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
   localparam logic [CNT_W-1:0] CNT_ONE  = 24'h000001;
   localparam logic [CNT_W-1:0] CNT_MAX  = 24'hffffff;
   localparam logic [CNT_W-1:0] REC_LIM  = CNT_W'(REC_CYC);

   localparam logic TX_DOMINANT  = 1'b0;
   localparam logic TX_RECESSIVE = 1'b1;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } cpfsi_bus_req_t;

   typedef struct packed {
      logic canh_high;
      logic canh_low;
      logic canl_high;
      logic canl_low;
      logic canh_oc;
      logic canl_oc;
   } cpfsi_mon_t;

   typedef enum logic {TO_IDLE, TO_TRIPPED} cpfsi_to_state_t;

   typedef struct packed {
      logic [DATA_W-1:0] status;
      logic [DATA_W-1:0] irq_en;
      logic [DATA_W-1:0] irq_flags;
      logic [DATA_W-1:0] rsvd_a;
      logic [DATA_W-1:0] rsvd_b;
      logic [CNT_W-1:0]  run_cnt;
      logic              tx_prev;
      cpfsi_to_state_t   to_state;
      logic              lo_latched;
      logic              rearm;
      logic [DATA_W-1:0] rd_data;
   } cpfsi_state_t;

   localparam cpfsi_state_t STATE_RST = '{
      status:     STATUS_RST,
      irq_en:     IRQ_EN_RST,
      irq_flags:  IRQ_FLAGS_RST,
      rsvd_a:     RSVD_RST,
      rsvd_b:     RSVD_RST,
      run_cnt:    CNT_ZERO,
      tx_prev:    TX_RECESSIVE,
      to_state:   TO_IDLE,
      lo_latched: 1'b0,
      rearm:      1'b0,
      rd_data:    READ_NONE
   };

endpackage : cpfsi_pkg

/* File: cpfsi_top.sv */
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
// Notes on behaviour
// - status bit 7 mirrors CANH high comparator
// - status bit 6 mirrors CANH low comparator
// - status bit 5 mirrors CANL high comparator
// - status bit 4 mirrors CANL low comparator
// - bit 3 sets after long dominant transmit
// - bit 3 clears after recessive over 1us
// - status register read only, writes ignored
// - reserved registers writable only in special mode
// - voltage enable gates four voltage flags
// - timeout enable gates timeout flag
// - overcurrent enable gates both overcurrent flags
// - enable register read/write, unused bits zero
// - writing one clears flag, zero no effect
// - enabled asserted flag raises error interrupt
// - flag 7 sets on CANH high change
// - flag 6 sets on CANH low change
// - flag 5 sets on CANL high change
// - flag 4 sets on CANL low change
// - flag 3 sets on timeout, forces listen-only
// - flags 1,0 on overcurrent while transmit is dominant; hold listen-only
module cpfsi_top #(
   parameter int unsigned TX_DOM_TIMEOUT_CYC =
      cpfsi_pkg::TX_DOM_TIMEOUT_CYC_DEF
) (
   input  wire logic                              core_clk,
   input  wire logic                              srst,
   input  wire cpfsi_pkg::cpfsi_bus_req_t         bus_req,
   output logic        [cpfsi_pkg::DATA_W-1:0]    rd_data,
   input  wire cpfsi_pkg::cpfsi_mon_t             mon,
   input  wire logic                              phy_tx_input,
   input  wire logic                              special_mode,
   output logic                                   error_irq,
   output logic                                   listen_only
);
   import cpfsi_pkg::*;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic flag_upd(input logic cur,
                                     input logic set,
                                     input logic clr);
      flag_upd = set | (cur & ~clr);
   endfunction : flag_upd

   function automatic logic hit(input cpfsi_bus_req_t req,
                                input logic [ADDR_W-1:0] ofs);
      hit = (req.addr == ofs);
   endfunction : hit

   localparam logic [CNT_W-1:0] DOM_LIM = CNT_W'(TX_DOM_TIMEOUT_CYC);

   cpfsi_state_t      r_reg;
   cpfsi_state_t      r_next;
   logic              tx_dom;
   logic [CNT_W-1:0]  run_next;
   logic              timeout_event;
   logic              tripped_next;
   logic [DATA_W-1:0] flag_set;
   logic [DATA_W-1:0] flag_clr;
   logic              wr_flags;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      r_next        = r_reg;
      tx_dom        = (phy_tx_input == TX_DOMINANT);
      timeout_event = 1'b0;
      flag_set      = READ_NONE;
      flag_clr      = READ_NONE;
      wr_flags      = bus_req.wr && hit(bus_req, OFS_IRQ_FLAGS);

      // length of the current transmit level, saturating
      if (phy_tx_input != r_reg.tx_prev) begin
         run_next = CNT_ONE;
      end else if (r_reg.run_cnt == CNT_MAX) begin
         run_next = r_reg.run_cnt;
      end else begin
         run_next = r_reg.run_cnt + CNT_ONE;
      end
      r_next.run_cnt = run_next;
      r_next.tx_prev = phy_tx_input;

      // dominant timeout monitor
      unique case (r_reg.to_state)
         TO_IDLE: begin
            if (tx_dom && (run_next > DOM_LIM)) begin
               r_next.to_state = TO_TRIPPED;
               timeout_event   = 1'b1;
            end
         end
         TO_TRIPPED: begin
            if (!tx_dom && (run_next > REC_LIM)) begin
               r_next.to_state = TO_IDLE;
            end
         end
      endcase
      tripped_next = (r_next.to_state == TO_TRIPPED);

      // status mirrors, bus writes never reach this register
      r_next.status                = STATUS_RST;
      r_next.status[BIT_CANH_HIGH] = mon.canh_high;
      r_next.status[BIT_CANH_LOW]  = mon.canh_low;
      r_next.status[BIT_CANL_HIGH] = mon.canl_high;
      r_next.status[BIT_CANL_LOW]  = mon.canl_low;
      r_next.status[BIT_TIMEOUT]   = tripped_next;

      // flag set conditions
      flag_set[BIT_CANH_HIGH] =
         mon.canh_high ^ r_reg.status[BIT_CANH_HIGH];
      flag_set[BIT_CANH_LOW]  =
         mon.canh_low ^ r_reg.status[BIT_CANH_LOW];
      flag_set[BIT_CANL_HIGH] =
         mon.canl_high ^ r_reg.status[BIT_CANL_HIGH];
      flag_set[BIT_CANL_LOW]  =
         mon.canl_low ^ r_reg.status[BIT_CANL_LOW];
      flag_set[BIT_TIMEOUT]   = timeout_event | r_reg.rearm;
      flag_set[BIT_CANH_OC]   = mon.canh_oc & tx_dom;
      flag_set[BIT_CANL_OC]   = mon.canl_oc & tx_dom;

      // write one to clear
      if (wr_flags) begin
         flag_clr = bus_req.wdata & IRQ_FLAGS_MASK;
      end
      for (int i = 0; i < DATA_W; i++) begin
         r_next.irq_flags[i] = flag_upd(r_reg.irq_flags[i],
                                        flag_set[i],
                                        flag_clr[i]);
      end
      r_next.irq_flags = r_next.irq_flags & IRQ_FLAGS_MASK;

      // clearing the timeout flag too early sets it again next cycle
      r_next.rearm = flag_clr[BIT_TIMEOUT] & (tripped_next | tx_dom);

      // listen-only latch entered at timeout
      if (timeout_event) begin
         r_next.lo_latched = 1'b1;
      end else if (!r_next.irq_flags[BIT_TIMEOUT] && !tripped_next &&
                   !tx_dom && !r_next.rearm) begin
         r_next.lo_latched = 1'b0;
      end

      // register writes
      if (bus_req.wr) begin
         if (hit(bus_req, OFS_IRQ_EN)) begin
            r_next.irq_en = bus_req.wdata & IRQ_EN_MASK;
         end
         if (hit(bus_req, OFS_RSVD_A) && special_mode) begin
            r_next.rsvd_a = bus_req.wdata;
         end
         if (hit(bus_req, OFS_RSVD_B) && special_mode) begin
            r_next.rsvd_b = bus_req.wdata;
         end
      end

      // read data stands for one cycle only
      r_next.rd_data = READ_NONE;
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            OFS_STATUS:    r_next.rd_data = r_reg.status;
            OFS_RSVD_A:    r_next.rd_data = r_reg.rsvd_a;
            OFS_RSVD_B:    r_next.rd_data = r_reg.rsvd_b;
            OFS_IRQ_EN:    r_next.rd_data = r_reg.irq_en;
            OFS_IRQ_FLAGS: r_next.rd_data = r_reg.irq_flags;
            default:       r_next.rd_data = READ_NONE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         r_reg <= STATE_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign rd_data = r_reg.rd_data;

   assign error_irq =
      (r_reg.irq_en[BIT_VF_EN] &
       (|(r_reg.irq_flags & VF_FLAGS_MASK))) |
      (r_reg.irq_en[BIT_DT_EN] &
       r_reg.irq_flags[BIT_TIMEOUT]) |
      (r_reg.irq_en[BIT_OC_EN] &
       (|(r_reg.irq_flags & OC_FLAGS_MASK)));

   assign listen_only =
      r_reg.lo_latched | (|(r_reg.irq_flags & OC_FLAGS_MASK));

endmodule : cpfsi_top

/* File: cpfsi_top_properties.sv */
`timescale 1ns/1ps
module cpfsi_top_properties #(
   parameter int unsigned TX_DOM_TIMEOUT_CYC =
      cpfsi_pkg::TX_DOM_TIMEOUT_CYC_DEF
) (
   input wire logic                      core_clk,
   input wire logic                      srst,
   input wire cpfsi_pkg::cpfsi_bus_req_t bus_req,
   input wire logic [7:0]                rd_data,
   input wire cpfsi_pkg::cpfsi_mon_t     mon,
   input wire logic                      phy_tx_input,
   input wire logic                      special_mode,
   input wire logic                      error_irq,
   input wire logic                      listen_only
);
   import cpfsi_pkg::*;
   logic [7:0]  en_q;
   logic [15:0] dom_cnt;
   logic [15:0] trip;
   assign trip = 16'(TX_DOM_TIMEOUT_CYC + 1);
   // -----------------------------------
   // shadow of enables, dominant run
   // -----------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         en_q    <= 8'h00;
         dom_cnt <= 16'h0000;
      end else begin
         if (bus_req.wr && bus_req.addr == OFS_IRQ_EN)
            en_q <= bus_req.wdata & IRQ_EN_MASK;
         dom_cnt <= phy_tx_input ? 16'h0000 : dom_cnt + 16'h0001;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   canh_chg_a:
      assert property (($changed(mon.canh_high) || $changed(mon.canh_low))
         && en_q[4] && !(bus_req.wr && bus_req.addr == OFS_IRQ_EN)
         |=> error_irq)
      else $error("canh change gave no irq");
   canl_chg_a:
      assert property (($changed(mon.canl_high) || $changed(mon.canl_low))
         && en_q[4] && !(bus_req.wr && bus_req.addr == OFS_IRQ_EN)
         |=> error_irq)
      else $error("canl change gave no irq");
   oc_flag_a:
      assert property ((mon.canh_oc || mon.canl_oc) && !phy_tx_input
         && en_q[0] && !bus_req.wr |=> error_irq && listen_only)
      else $error("overcurrent missed");
   to_trip_a:
      assert property (dom_cnt == trip |-> listen_only)
      else $error("timeout trip missed");
   to_irq_a:
      assert property (dom_cnt == trip && en_q[3] |-> error_irq)
      else $error("timeout irq missed");
   lo_cause_a:
      assert property ($rose(listen_only) |-> dom_cnt == trip ||
         $past((mon.canh_oc || mon.canl_oc) && !phy_tx_input))
      else $error("listen only without cause");
   en_read_a:
      assert property (bus_req.rd && bus_req.addr == OFS_IRQ_EN
         |=> rd_data == en_q)
      else $error("enable readback wrong");
   irq_gate_a:
      assert property (en_q == 8'h00 |-> !error_irq)
      else $error("irq while disabled");
   cover property (dom_cnt == trip);
   cover property (error_irq && en_q[4]);
   cover property (bus_req.wr && bus_req.addr == OFS_RSVD_A && special_mode);
endmodule : cpfsi_top_properties

/* File: cpfsi_phy_model.sv */
`timescale 1ns/1ps
module cpfsi_phy_model (
   input  wire logic                  core_clk,
   input  wire cpfsi_pkg::cpfsi_mon_t mon_cmd,
   input  wire logic [31:0]           dom_len,
   input  wire logic                  go,
   output cpfsi_pkg::cpfsi_mon_t      mon,
   output logic                       phy_tx_input
);
   import cpfsi_pkg::*;
   logic [31:0] left = 32'h0;
   // -----------------------------------
   // bus monitors and dominant runs
   // -----------------------------------
   initial mon = '0;
   always @(posedge core_clk) begin
      mon <= mon_cmd;
      if (go)
         left <= dom_len;
      else if (left != 32'h0)
         left <= left - 32'h1;
   end
   assign phy_tx_input = (left == 32'h0) ? TX_RECESSIVE : TX_DOMINANT;
endmodule : cpfsi_phy_model

/* File: cpfsi_top_test.sv */
`timescale 1ns/1ps
module cpfsi_top_test;
   import cpfsi_pkg::*;
   localparam int unsigned N = 40;
   logic           core_clk = 1'b0;
   logic           srst = 1'b1;
   cpfsi_bus_req_t bus_req = '0;
   cpfsi_mon_t     mon;
   cpfsi_mon_t     mon_cmd = '0;
   logic [7:0]     rd_data;
   logic [31:0]    dom_len = 32'h0;
   logic           go = 1'b0;
   logic           special_mode = 1'b0;
   logic           phy_tx_input;
   logic           error_irq;
   logic           listen_only;
   int             err_count = 0;
   int             cmp_count = 0;
   int             cyc = 0;
   always #25 core_clk = ~core_clk;
   cpfsi_top #(.TX_DOM_TIMEOUT_CYC(N)) i_dut (
      .core_clk(core_clk), .srst(srst), .bus_req(bus_req),
      .rd_data(rd_data), .mon(mon), .phy_tx_input(phy_tx_input),
      .special_mode(special_mode), .error_irq(error_irq),
      .listen_only(listen_only));
   cpfsi_phy_model i_phy (.core_clk(core_clk), .mon_cmd(mon_cmd),
      .dom_len(dom_len), .go(go), .mon(mon), .phy_tx_input(phy_tx_input));
   // -----------------------------------
   // bus and compare tasks
   // -----------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      bus_req.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      bus_req.rd <= 1'b0;
      #1 chk(rd_data, exp);
   endtask : rd
   task automatic dom(input logic [31:0] len);
      dom_len <= len;
      go      <= 1'b1;
      @(posedge core_clk);
      go      <= 1'b0;
   endtask : dom
   // -----------------------------------
   // scenarios
   // -----------------------------------
   task automatic t_regs;
      rd(OFS_STATUS, STATUS_RST);
      rd(OFS_IRQ_FLAGS, IRQ_FLAGS_RST);
      wr(OFS_STATUS, 8'hff);
      rd(OFS_STATUS, 8'h00);
      wr(OFS_IRQ_EN, 8'hff);
      rd(OFS_IRQ_EN, 8'h19);
      wr(OFS_RSVD_A, 8'ha5);
      wr(OFS_RSVD_B, 8'h5a);
      rd(OFS_RSVD_A, 8'h00);
      rd(OFS_RSVD_B, 8'h00);
      special_mode <= 1'b1;
      wr(OFS_RSVD_A, 8'ha5);
      wr(OFS_RSVD_B, 8'h5a);
      rd(OFS_RSVD_A, 8'ha5);
      rd(OFS_RSVD_B, 8'h5a);
      special_mode <= 1'b0;
      rd(8'h10, 8'h00);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_volt;
      logic [7:0] b;
      wr(OFS_IRQ_EN, 8'h10);
      for (int i = 0; i < 4; i++) begin
         b = 8'h80 >> i;
         mon_cmd <= 6'h20 >> i;
         repeat (3) @(posedge core_clk);
         rd(OFS_STATUS, b);
         chk({7'h00, error_irq}, 8'h01);
         wr(OFS_IRQ_FLAGS, ~b);
         rd(OFS_IRQ_FLAGS, b);
         wr(OFS_IRQ_FLAGS, b);
         rd(OFS_IRQ_FLAGS, 8'h00);
         // the falling change reaches the flag on the edge of the clear
         mon_cmd <= 6'h00;
         wr(OFS_IRQ_FLAGS, b);
         rd(OFS_IRQ_FLAGS, b);
         wr(OFS_IRQ_FLAGS, b);
      end
      $display("t_volt done");
   endtask : t_volt
   task automatic t_to;
      int n;
      wr(OFS_IRQ_EN, 8'h08);
      dom(N + 30);
      n = 0;
      while (listen_only !== 1'b1 && n < 200) begin
         @(posedge core_clk);
         #1 n++;
      end
      chk(8'(n), 8'(N + 1));
      chk({7'h00, error_irq}, 8'h01);
      rd(OFS_STATUS, 8'h08);
      wr(OFS_IRQ_FLAGS, 8'h08);
      repeat (2) @(posedge core_clk);
      rd(OFS_IRQ_FLAGS, 8'h08);
      wait (phy_tx_input === 1'b1);
      repeat (10) @(posedge core_clk);
      rd(OFS_STATUS, 8'h08);
      repeat (12) @(posedge core_clk);
      rd(OFS_STATUS, 8'h00);
      wr(OFS_IRQ_FLAGS, 8'h08);
      rd(OFS_IRQ_FLAGS, 8'h00);
      chk({7'h00, listen_only}, 8'h00);
      $display("t_to done");
   endtask : t_to
   task automatic t_oc;
      wr(OFS_IRQ_EN, 8'h01);
      for (int i = 0; i < 2; i++) begin
         mon_cmd <= 6'h02 >> i;
         repeat (3) @(posedge core_clk);
         rd(OFS_IRQ_FLAGS, 8'h00);
         dom(5);
         repeat (8) @(posedge core_clk);
         #1 chk({6'h00, listen_only, error_irq}, 8'h03);
         rd(OFS_IRQ_FLAGS, 8'h02 >> i);
         mon_cmd <= 6'h00;
         wr(OFS_IRQ_FLAGS, 8'h02 >> i);
         rd(OFS_IRQ_FLAGS, 8'h00);
         chk({7'h00, listen_only}, 8'h00);
      end
      $display("t_oc done");
   endtask : t_oc
   task automatic stop_test;
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : stop_test
   initial begin
      repeat (4) @(posedge core_clk);
      srst <= 1'b0;
      t_regs;
      t_volt;
      t_to;
      t_oc;
      stop_test;
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc > 3000) begin
         err_count++;
         stop_test;
      end
   end
endmodule : cpfsi_top_test
bind cpfsi_top cpfsi_top_properties #(
   .TX_DOM_TIMEOUT_CYC(TX_DOM_TIMEOUT_CYC)) i_props (
   .core_clk(core_clk), .srst(srst), .bus_req(bus_req),
   .rd_data(rd_data), .mon(mon), .phy_tx_input(phy_tx_input),
   .special_mode(special_mode), .error_irq(error_irq),
   .listen_only(listen_only));
